// [rtl/tmw_pkg.sv]
// constants for the 16-bit timer waveform block: register map, field
// positions, reset values and waveform mode codes.
// assumes a 32-bit axi4-lite register bus with byte addresses.
package tmw_pkg;
   // register byte offsets
   localparam logic [7:0] TMW_OFF_CTRL  = 8'h00;
   localparam logic [7:0] TMW_OFF_FORCE = 8'h04;
   localparam logic [7:0] TMW_OFF_COUNT = 8'h08;
   localparam logic [7:0] TMW_OFF_CMPA  = 8'h0C;
   localparam logic [7:0] TMW_OFF_CMPB  = 8'h10;
   localparam logic [7:0] TMW_OFF_CAPT  = 8'h14;
   localparam logic [7:0] TMW_OFF_FLAGS = 8'h18;
   localparam logic [7:0] TMW_OFF_STAT  = 8'h1C;
   // control field positions
   localparam int TMW_CTRL_MODE_LSB = 0;   // waveform mode field, 4 bits
   localparam int TMW_CTRL_CSEL_LSB = 4;   // clock select, 3 bits
   localparam int TMW_CTRL_COMA_LSB = 8;   // channel a output mode, 2 bits
   localparam int TMW_CTRL_COMB_LSB = 10;  // channel b output mode, 2 bits
   localparam int TMW_CTRL_DIR_LSB  = 12;  // pin direction a, b
   localparam int TMW_CTRL_PORT_LSB = 14;  // general port value a, b
   // flag positions
   localparam int TMW_FLG_OVF  = 0;
   localparam int TMW_FLG_MA   = 1;
   localparam int TMW_FLG_MB   = 2;
   localparam int TMW_FLG_CAPT = 3;
   // reset values
   localparam logic [15:0] TMW_CTRL_RST = 16'h0000;
   localparam logic [15:0] TMW_CNT_RST  = 16'h0000;
   localparam logic [15:0] TMW_CMP_RST  = 16'h0000;
   // fixed counter limits
   localparam logic [15:0] TMW_MAX   = 16'hFFFF;
   localparam logic [15:0] TMW_TOP8  = 16'h00FF;
   localparam logic [15:0] TMW_TOP9  = 16'h01FF;
   localparam logic [15:0] TMW_TOP10 = 16'h03FF;
   // waveform mode codes
   localparam logic [3:0] TMW_WM_NORMAL   = 4'h0;
   localparam logic [3:0] TMW_WM_CTC_A    = 4'h4;
   localparam logic [3:0] TMW_WM_FAST8    = 4'h5;
   localparam logic [3:0] TMW_WM_FAST9    = 4'h6;
   localparam logic [3:0] TMW_WM_FAST10   = 4'h7;
   localparam logic [3:0] TMW_WM_CTC_CAPT = 4'hC;
   localparam logic [3:0] TMW_WM_FAST_CAP = 4'hE;
   localparam logic [3:0] TMW_WM_FAST_A   = 4'hF;
   // clock select codes: stop, /1, /8, /64, /256, /1024
   localparam logic [2:0] TMW_CS_DIV1    = 3'h1;
   localparam logic [2:0] TMW_CS_DIV8    = 3'h2;
   localparam logic [2:0] TMW_CS_DIV64   = 3'h3;
   localparam logic [2:0] TMW_CS_DIV256  = 3'h4;
   localparam logic [2:0] TMW_CS_DIV1024 = 3'h5;
   // output mode codes
   localparam logic [1:0] TMW_COM_OFF    = 2'h0;
   localparam logic [1:0] TMW_COM_TOGGLE = 2'h1;
   localparam logic [1:0] TMW_COM_CLEAR  = 2'h2;
   localparam logic [1:0] TMW_COM_SET    = 2'h3;
   // axi responses
   localparam logic [1:0] TMW_RESP_OKAY   = 2'h0;
   localparam logic [1:0] TMW_RESP_SLVERR = 2'h2;
endpackage

// [rtl/tmw_timer16.sv]
// 16-bit timer/counter with two compare output channels, normal, clear on
// match and single-slope fast pwm counting, reached over axi4-lite.
// assumes one 250 mhz clock, active-low async reset, synchronous inputs.
//
// Notes on behaviour
// - nonzero output mode: pin driven by output state
// - pin direction still from direction bit
// - reset clears the output state flops
// - output mode zero: match leaves state alone
// - new output mode acts at next match
// - force strobe applies action at once, non-pwm
// - output mode never shapes the count
// - mode zero counts up, wraps ffff to 0
// - normal overflow flag set as count becomes 0
// - hardware only sets the overflow flag
// - clear on match: top is cmp a or capture
// - reaching top sets cmp a or capture flag
// - unbuffered top; missed top wraps through ffff
// - mode 1 toggles channel a on each match
// - clear on match overflow at max to 0
// - prescaler ticks /1 /8 /64 /256 /1024
// - fast pwm modes count bottom to top, restart
// - fast pwm: clear on match, set at bottom
// - fast pwm tops: ff, 1ff, 3ff, capture, cmp a
// - after top the next tick clears counter
// - fast pwm match sets channel flag
// - fast pwm mode 2 normal, 3 inverted
// - fast pwm compare reloads from buffer at top
// - fast pwm overflow set at top with top flag
//
// Implementation choices: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module tmw_timer16
   import tmw_pkg::*;
(
   input  wire  logic        clk,
   input  wire  logic        rst_n,
   input  wire  logic [7:0]  s_axi_awaddr,
   input  wire  logic        s_axi_awvalid,
   output var   logic        s_axi_awready,
   input  wire  logic [31:0] s_axi_wdata,
   input  wire  logic [3:0]  s_axi_wstrb,
   input  wire  logic        s_axi_wvalid,
   output var   logic        s_axi_wready,
   output var   logic [1:0]  s_axi_bresp,
   output var   logic        s_axi_bvalid,
   input  wire  logic        s_axi_bready,
   input  wire  logic [7:0]  s_axi_araddr,
   input  wire  logic        s_axi_arvalid,
   output var   logic        s_axi_arready,
   output var   logic [31:0] s_axi_rdata,
   output var   logic [1:0]  s_axi_rresp,
   output var   logic        s_axi_rvalid,
   input  wire  logic        s_axi_rready,
   output var   logic [1:0]  pinOut,
   output var   logic [1:0]  pinOe
);

   ////////////////////////////////////////////////////////////////////////
   // declarations
   logic [15:0] ctrlQ;                 // control register
   logic [15:0] cntQ;                  // counter value
   logic [15:0] captQ;                 // capture value register
   logic [15:0] cmpBufQ [2];           // software-visible compare values
   logic [15:0] cmpActQ [2];           // active compare values in pwm
   logic [15:0] cmpEff  [2];           // compare value actually used
   logic [3:0]  flagQ;                 // sticky event flags
   logic [1:0]  outStateQ;             // internal compare output states
   logic        blockQ;                // suppress matches for one tick
   logic [9:0]  prescQ;                // free-running prescaler
   logic        tick;                  // timer clock enable
   logic [3:0]  mode;                  // waveform mode field
   logic [2:0]  clkSel;                // clock select
   logic [1:0]  com     [2];           // output mode bits per channel
   logic        isPwm;                 // fast pwm modes
   logic        isCtc;                 // clear on match modes
   logic [15:0] top;                   // current top value
   logic        atTop;                 // counter equals top, clearing modes
   logic [1:0]  match;                 // unblocked compare matches
   logic        wrFire;                // write handshake this cycle
   logic        rdFire;                // read handshake this cycle
   logic        cntWr;                 // software writes the counter
   logic [1:0]  forceStb;              // force strobes
   logic        wrHit;                 // write address is mapped
   logic        rdHit;                 // read address is mapped
   logic [31:0] rdData;                // read mux

   assign mode   = ctrlQ[TMW_CTRL_MODE_LSB +: 4];
   assign clkSel = ctrlQ[TMW_CTRL_CSEL_LSB +: 3];
   assign com[0] = ctrlQ[TMW_CTRL_COMA_LSB +: 2];
   assign com[1] = ctrlQ[TMW_CTRL_COMB_LSB +: 2];

   // merge a write under byte strobes
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] val,
                                         input logic [3:0]  strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            res[8*i +: 8] = val[8*i +: 8];
         end
      end
      return res;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite write channel: address and data taken together
   assign wrFire = s_axi_awvalid && s_axi_awready;
   assign wrHit  = (s_axi_awaddr[7:5] == 3'h0) && (s_axi_awaddr[1:0] == 2'h0);
   assign cntWr  = wrFire && (s_axi_awaddr == TMW_OFF_COUNT);
   assign forceStb = (wrFire && (s_axi_awaddr == TMW_OFF_FORCE)) ? s_axi_wdata[1:0] & {2{s_axi_wstrb[0]}} : 2'b00;

   // ready pulses once both channels are offered, response follows
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= TMW_RESP_OKAY;
      end else begin
         s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         s_axi_wready  <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
         if (wrFire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wrHit ? TMW_RESP_OKAY : TMW_RESP_SLVERR;
         end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // axi4-lite read channel
   assign rdFire = s_axi_arvalid && s_axi_arready;
   assign rdHit  = (s_axi_araddr[7:5] == 3'h0) && (s_axi_araddr[1:0] == 2'h0);

   // read mux, unmapped reads zero
   always_comb begin
      rdData = 32'h0000_0000;
      unique case (s_axi_araddr)
         TMW_OFF_CTRL:  rdData = {16'h0000, ctrlQ};
         TMW_OFF_COUNT: rdData = {16'h0000, cntQ};
         TMW_OFF_CMPA:  rdData = {16'h0000, cmpBufQ[0]};
         TMW_OFF_CMPB:  rdData = {16'h0000, cmpBufQ[1]};
         TMW_OFF_CAPT:  rdData = {16'h0000, captQ};
         TMW_OFF_FLAGS: rdData = {28'h0000000, flagQ};
         TMW_OFF_STAT:  rdData = {30'h0, outStateQ};
         default:       rdData = 32'h0000_0000;   // force register and holes
      endcase
   end

   // one read at a time, data registered with rvalid
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= TMW_RESP_OKAY;
      end else begin
         s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
         if (rdFire) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rdData;
            s_axi_rresp  <= rdHit ? TMW_RESP_OKAY : TMW_RESP_SLVERR;
         end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // software-written configuration
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrlQ <= TMW_CTRL_RST;
         captQ <= TMW_CMP_RST;
      end else if (wrFire) begin
         // output mode bits take effect on the very next match
         if (s_axi_awaddr == TMW_OFF_CTRL) begin
            ctrlQ <= 16'(merge({16'h0000, ctrlQ}, s_axi_wdata, s_axi_wstrb));
         end
         // capture register is never buffered
         if (s_axi_awaddr == TMW_OFF_CAPT) begin
            captQ <= 16'(merge({16'h0000, captQ}, s_axi_wdata, s_axi_wstrb));
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // prescaler and tick select
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prescQ <= 10'h000;
      end else begin
         prescQ <= prescQ + 10'h001;
      end
   end

   // counter advances only on the selected division
   always_comb begin
      unique case (clkSel)
         TMW_CS_DIV1:    tick = 1'b1;
         TMW_CS_DIV8:    tick = &prescQ[2:0];
         TMW_CS_DIV64:   tick = &prescQ[5:0];
         TMW_CS_DIV256:  tick = &prescQ[7:0];
         TMW_CS_DIV1024: tick = &prescQ[9:0];
         default:        tick = 1'b0;   // stopped or reserved
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // top selection from the waveform mode field only
   always_comb begin
      isPwm = 1'b0;
      isCtc = 1'b0;
      top   = TMW_MAX;
      unique case (mode)
         TMW_WM_CTC_A:    begin isCtc = 1'b1; top = cmpBufQ[0]; end
         TMW_WM_CTC_CAPT: begin isCtc = 1'b1; top = captQ;      end
         TMW_WM_FAST8:    begin isPwm = 1'b1; top = TMW_TOP8;   end
         TMW_WM_FAST9:    begin isPwm = 1'b1; top = TMW_TOP9;   end
         TMW_WM_FAST10:   begin isPwm = 1'b1; top = TMW_TOP10;  end
         TMW_WM_FAST_CAP: begin isPwm = 1'b1; top = captQ;      end
         TMW_WM_FAST_A:   begin isPwm = 1'b1; top = cmpActQ[0]; end
         default:         begin top = TMW_MAX; end                    // plain up count
      endcase
   end

   // a missed register top runs on to ffff and wraps
   assign atTop = (isPwm || isCtc) && (cntQ == top) && !blockQ;

   ////////////////////////////////////////////////////////////////////////
   // counter: up only, cleared after top in clearing modes
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cntQ   <= TMW_CNT_RST;
         blockQ <= 1'b0;
      end else if (cntWr) begin
         cntQ   <= 16'(merge({16'h0000, cntQ}, s_axi_wdata, s_axi_wstrb));
         blockQ <= 1'b1;   // next tick sees no match
      end else if (tick) begin
         blockQ <= 1'b0;
         if (atTop) begin
            cntQ <= TMW_CNT_RST;
         end else begin
            cntQ <= cntQ + 16'h0001;    // wraps ffff to 0000
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // flags: hardware sets, software clears by writing one; set wins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         flagQ <= 4'h0;
      end else begin
         logic [3:0] setV;
         logic [3:0] clrV;
         setV = 4'h0;
         clrV = 4'h0;
         if (tick && !cntWr) begin
            // overflow as count becomes zero at top in pwm
            setV[TMW_FLG_OVF]  = isPwm ? atTop : (cntQ == TMW_MAX);
            setV[TMW_FLG_MA]   = match[0] || (atTop && (mode == TMW_WM_CTC_A || mode == TMW_WM_FAST_A));
            setV[TMW_FLG_MB]   = match[1];
            setV[TMW_FLG_CAPT] = atTop && (mode == TMW_WM_CTC_CAPT || mode == TMW_WM_FAST_CAP);
         end
         if (wrFire && s_axi_awaddr == TMW_OFF_FLAGS && s_axi_wstrb[0]) begin
            clrV = s_axi_wdata[3:0];
         end
         flagQ <= (flagQ & ~clrV) | setV;   // counter logic never clears
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // per-channel compare, output state and pin
   for (genvar ch = 0; ch < 2; ch++) begin : g_chan
      logic [7:0] offCmp;   // this channel's compare offset
      logic       nextSt;   // output state after this cycle
      assign offCmp = (ch == 0) ? TMW_OFF_CMPA : TMW_OFF_CMPB;

      // compare buffer written by software
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            cmpBufQ[ch] <= TMW_CMP_RST;
         end else if (wrFire && s_axi_awaddr == offCmp) begin
            cmpBufQ[ch] <= 16'(merge({16'h0000, cmpBufQ[ch]}, s_axi_wdata, s_axi_wstrb));
         end
      end

      // active compare: reloads at top in pwm, tracks buffer otherwise
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            cmpActQ[ch] <= TMW_CMP_RST;
         end else if (!isPwm || (tick && atTop && !cntWr)) begin
            cmpActQ[ch] <= cmpBufQ[ch];
         end
      end

      assign cmpEff[ch] = isPwm ? cmpActQ[ch] : cmpBufQ[ch];
      assign match[ch]  = (cntQ == cmpEff[ch]) && !blockQ;

      // output action from mode bits; zero leaves the state alone
      always_comb begin
         nextSt = outStateQ[ch];
         if (isPwm) begin
            if (tick && !cntWr) begin
               if (com[ch] == TMW_COM_TOGGLE) begin
                  // toggle only on channel a with cmp a as top
                  if (ch == 0 && mode == TMW_WM_FAST_A && match[ch]) begin
                     nextSt = !outStateQ[ch];
                  end
               end else if (com[ch] != TMW_COM_OFF) begin
                  // bottom wins so compare equal to top holds a level
                  if (atTop) begin
                     nextSt = (com[ch] == TMW_COM_CLEAR);
                  end else if (match[ch]) begin
                     nextSt = (com[ch] == TMW_COM_SET);
                  end
               end
            end
         end else if (forceStb[ch] || (tick && !cntWr && match[ch])) begin
            // forced or real match, same action
            unique case (com[ch])
               TMW_COM_TOGGLE: nextSt = !outStateQ[ch];
               TMW_COM_CLEAR:  nextSt = 1'b0;
               TMW_COM_SET:    nextSt = 1'b1;
               default:        nextSt = outStateQ[ch];
            endcase
         end
      end

      // output state flop, zero after reset
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            outStateQ[ch] <= 1'b0;
         end else begin
            outStateQ[ch] <= nextSt;
         end
      end

      // pin: override by output state, direction from its own bit
      always_ff @(posedge clk or negedge rst_n) begin
         if (!rst_n) begin
            pinOut[ch] <= 1'b0;
            pinOe[ch]  <= 1'b0;
         end else begin
            pinOut[ch] <= (com[ch] != TMW_COM_OFF) ? nextSt : ctrlQ[TMW_CTRL_PORT_LSB + ch];
            pinOe[ch]  <= ctrlQ[TMW_CTRL_DIR_LSB + ch];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence sCount;
      tick && !cntWr;
   endsequence
   sequence sPwmTop;
      sCount ##0 isPwm && atTop;
   endsequence

   a_normal_wrap: assert property (sCount ##0 mode == TMW_WM_NORMAL && cntQ == TMW_MAX
      |=> cntQ == 16'h0000 && flagQ[TMW_FLG_OVF]) else $error("normal wrap or overflow flag wrong");
   a_normal_inc: assert property (sCount ##0 mode == TMW_WM_NORMAL
      |=> cntQ == $past(cntQ) + 16'h0001) else $error("normal count not incrementing");
   a_ctc_clear: assert property (sCount ##0 isCtc && atTop
      |=> cntQ == 16'h0000 ##0 (flagQ[TMW_FLG_MA] || flagQ[TMW_FLG_CAPT])) else $error("ctc top not cleared");
   a_pwm_top: assert property (sPwmTop |=> cntQ == 16'h0000 && flagQ[TMW_FLG_OVF]) else $error("pwm top not cleared");
   a_pwm_reload: assert property (sPwmTop |=> cmpActQ[0] == $past(cmpBufQ[0])) else $error("compare not reloaded at top");
   a_pwm_bottom: assert property (sPwmTop ##0 com[0] == TMW_COM_CLEAR |=> outStateQ[0]) else $error("noninverted not set at bottom");
   a_com_zero: assert property (com[0] == TMW_COM_OFF |=> outStateQ[0] == $past(outStateQ[0])) else $error("state moved with mode zero");
   a_force_toggle: assert property (forceStb[0] && !isPwm && com[0] == TMW_COM_TOGGLE
      |=> outStateQ[0] != $past(outStateQ[0])) else $error("force did not toggle");
   a_ovf_sticky: assert property (flagQ[TMW_FLG_OVF] && !(wrFire && s_axi_awaddr == TMW_OFF_FLAGS)
      |=> flagQ[TMW_FLG_OVF]) else $error("overflow flag lost");
   a_pin_override: assert property (com[0] != TMW_COM_OFF |=> pinOut[0] == outStateQ[0]) else $error("pin not overridden");
   a_pin_dir: assert property (##1 pinOe[0] == $past(ctrlQ[TMW_CTRL_DIR_LSB])) else $error("pin direction wrong");
   a_write_block: assert property (cntWr ##1 (!tick)[*2] ##1 tick |-> !match[0] && !match[1]) else $error("match after counter write");

endmodule // tmw_timer16

`default_nettype wire

// [sim/tmw_pin_load.sv]
// external load on the two waveform pins: a pull-down per pin.
// assumes pinOut/pinOe come straight from the timer, high enable drives.
`timescale 1ns/100ps
`default_nettype none
module tmw_pin_load (
   input  wire logic [1:0] pinOut,   // driven level per channel
   input  wire logic [1:0] pinOe,    // drive enable per channel
   output var  logic [1:0] pinLevel  // level seen on the board
);
   // undriven pin falls to the pull-down, never keeps the last value
   always_comb pinLevel = pinOut & pinOe;
endmodule // tmw_pin_load
`default_nettype wire

// [sim/tb.sv]
// bench for the timer: axi4-lite register tasks and directed scenarios.
// assumes tmw_pkg, tmw_timer16 and the pull-down pin load model.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import tmw_pkg::*;
   ////////////////////////////////////////////////////////////
   logic clk = 0, rst_n = 0;
   logic [7:0] awaddr = 0, araddr = 0;      // bus addresses
   logic [31:0] wdata = 0, rdata;           // bus data
   logic [3:0] wstrb = 0;
   logic awvalid = 0, awready, wvalid = 0, wready, bvalid, bready = 0;
   logic arvalid = 0, arready, rvalid, rready = 0;
   logic [1:0] bresp, rresp, pinOut, pinOe, pinLevel;
   logic [31:0] rd;                         // last read word
   logic [1:0] rs;                          // last response
   int err_count = 0, compares = 0;
   logic [1:0] comTab [4] = '{2'h3, 2'h0, 2'h2, 2'h1};  // output modes
   logic       expTab [4] = '{1'b1, 1'b1, 1'b0, 1'b1};  // state after force
   always #2 clk = ~clk;  // 250 mhz
   tmw_timer16 i_tmw_timer16 (.clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pinOut(pinOut), .pinOe(pinOe));
   tmw_pin_load i_tmw_pin_load (.pinOut(pinOut), .pinOe(pinOe), .pinLevel(pinLevel));
   ////////////////////////////////////////////////////////////
   // one write: address and data offered together, held until taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1; bready <= 1;
      do @(posedge clk); while (awready !== 1'b1);
      awvalid <= 0; wvalid <= 0;
      do @(posedge clk); while (bvalid !== 1'b1);
      rs = bresp; bready <= 0;
      @(posedge clk);
   endtask
   // one read: response and data taken at the rvalid edge
   task automatic rdw(input logic [7:0] a);
      araddr <= a; arvalid <= 1; rready <= 1;
      do @(posedge clk); while (arready !== 1'b1);
      arvalid <= 0;
      do @(posedge clk); while (rvalid !== 1'b1);
      rd = rdata; rs = rresp; rready <= 0;
      @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
         err_count++;
      end
   endtask
   task automatic complete_run;
      $display("mismatches %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////
   // watchdog against a hung handshake
   initial begin
      #200000;
      err_count++;
      complete_run;
   end
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      rdw(TMW_OFF_STAT); chk(rd, 32'h0);
      chk({30'h0, pinOe}, 32'h0);
      rdw(8'h40); chk({30'h0, rs}, {30'h0, TMW_RESP_SLVERR});
      // force with each output mode in normal mode, pin a driven
      for (int i = 0; i < 4; i++) begin
         wr(TMW_OFF_CTRL, 32'h1000 | (32'(comTab[i]) << 8));
         wr(TMW_OFF_FORCE, 32'h1);
         rdw(TMW_OFF_STAT); chk({31'h0, rd[0]}, {31'h0, expTab[i]});
         chk({31'h0, pinLevel[0]}, {31'h0, (comTab[i] != 0) & expTab[i]});
      end
      wr(TMW_OFF_CTRL, 32'h5000); chk({31'h0, pinLevel[0]}, 32'h1);
      wr(TMW_OFF_CTRL, 32'h4000); chk({30'h0, pinOe}, 32'h0);
      // normal mode wrap from ffff to 0
      wr(TMW_OFF_COUNT, 32'hFFFE); wr(TMW_OFF_FLAGS, 32'hF);
      wr(TMW_OFF_CTRL, 32'h0010); wr(TMW_OFF_CTRL, 32'h0000);
      rdw(TMW_OFF_COUNT); chk({31'h0, rd < 32'd20}, 32'h1);
      rdw(TMW_OFF_FLAGS); chk({31'h0, rd[TMW_FLG_OVF]}, 32'h1);
      repeat (20) @(posedge clk);
      rdw(TMW_OFF_FLAGS); chk({31'h0, rd[TMW_FLG_OVF]}, 32'h1);
      // clear on match with cmp a = 5, toggle output
      wr(TMW_OFF_FLAGS, 32'hF); wr(TMW_OFF_CMPA, 32'h5); wr(TMW_OFF_COUNT, 32'h0);
      wr(TMW_OFF_CTRL, 32'h1114);
      repeat (60) @(posedge clk);
      wr(TMW_OFF_CTRL, 32'h1104);
      rdw(TMW_OFF_COUNT); chk({31'h0, rd <= 32'h5}, 32'h1);
      rdw(TMW_OFF_FLAGS); chk(rd & 32'h3, 32'h2);
      // fast pwm 8-bit top, compare a = 0x10 (register top kept >= 3)
      wr(TMW_OFF_FLAGS, 32'hF); wr(TMW_OFF_CMPA, 32'h10); wr(TMW_OFF_COUNT, 32'h0);
      wr(TMW_OFF_CTRL, 32'h1215);
      for (int i = 0; i < 6; i++) begin
         repeat (97) @(posedge clk);
         rdw(TMW_OFF_COUNT); chk({31'h0, rd <= 32'(TMW_TOP8)}, 32'h1);
      end
      wr(TMW_OFF_CTRL, 32'h1205);
      rdw(TMW_OFF_FLAGS); chk(rd & 32'h3, 32'h3);
      wr(TMW_OFF_FLAGS, 32'hF);
      rdw(TMW_OFF_FLAGS); chk(rd & 32'hF, 32'h0);
      complete_run;
   end
endmodule // tb
`default_nettype wire
